// [src/swr_pkg.sv]
// Purpose: shared constants for the single-wire rom function layer
// Assumes: 100 MHz core clock, one master and one slave on one line
// Notes:   times are kept in microseconds, cycle counts derive from them
package swr_pkg;

  // ---------------------------------------------------------------
  // clock and counter widths
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned CNT_W = 17;

  // ---------------------------------------------------------------
  // line timing, microseconds and derived cycles
  // ---------------------------------------------------------------
  localparam int unsigned RST_DET_US = 480;  // low longer than this resets slaves
  localparam int unsigned RST_DET_CYC = RST_DET_US * CLK_MHZ;
  localparam int unsigned RST_LOW_US = 500;  // master reset pulse, margin over 480
  localparam int unsigned RST_LOW_CYC = RST_LOW_US * CLK_MHZ;
  localparam int unsigned RST_WAIT_US = 480;
  localparam int unsigned RST_WAIT_CYC = RST_WAIT_US * CLK_MHZ;
  localparam int unsigned PRES_WAIT_US = 30;
  localparam int unsigned PRES_WAIT_CYC = PRES_WAIT_US * CLK_MHZ;
  localparam int unsigned PRES_END_US = 150;  // wait plus 120 us low
  localparam int unsigned PRES_END_CYC = PRES_END_US * CLK_MHZ;
  localparam int unsigned PRES_SMP_US = 70;
  localparam int unsigned PRES_SMP_CYC = PRES_SMP_US * CLK_MHZ;
  localparam int unsigned DEV_SLOT_US = 30;  // slave samples and releases here
  localparam int unsigned DEV_SLOT_CYC = DEV_SLOT_US * CLK_MHZ;
  localparam int unsigned MST_SLOT_US = 70;
  localparam int unsigned MST_SLOT_CYC = MST_SLOT_US * CLK_MHZ;
  localparam int unsigned W0_LOW_US = 60;
  localparam int unsigned W0_LOW_CYC = W0_LOW_US * CLK_MHZ;
  localparam int unsigned SHORT_LOW_US = 2;
  localparam int unsigned SHORT_LOW_CYC = SHORT_LOW_US * CLK_MHZ;
  localparam int unsigned RD_SMP_US = 13;
  localparam int unsigned RD_SMP_CYC = RD_SMP_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // rom function codes and crc
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ROM = 8'h33;
  localparam logic [7:0] CMD_MATCH_ROM = 8'h55;
  localparam logic [7:0] CMD_SKIP_ROM = 8'hcc;
  localparam logic [7:0] CMD_SEARCH_ROM = 8'hf0;
  localparam logic [7:0] CRC_POLY_REV = 8'h8c;  // x^8+x^5+x^4+1, shifted right

  typedef enum logic [1:0] {SWR_OP_RESET, SWR_OP_WRITE, SWR_OP_READ, SWR_OP_TRIPLET} swr_op_e;

  // crc of one more bit, lsb-first shift register
  function automatic logic [7:0] swr_crc_bit(input logic [7:0] crc, input logic b);
    logic fb;
    fb = crc[0] ^ b;
    swr_crc_bit = fb ? ((crc >> 1) ^ CRC_POLY_REV) : (crc >> 1);
  endfunction

  // crc over family code and serial number, bit 0 first
  function automatic logic [7:0] swr_crc56(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      c = swr_crc_bit(c, d[i]);
    end
    swr_crc56 = c;
  endfunction

endpackage

// [src/swr_link_if.sv]
// Purpose: the shared open-drain line between master and slave ends
// Assumes: a pull-up holds the line high when nobody pulls it low
// Notes:   wired-and of both ends; the line takes one slave end only
interface swr_link_if;
  logic dev_dq_o;
  logic dev_dq_oe;
  logic mst_dq_o;
  logic mst_dq_oe;
  logic dq;

  // released ends read as high through the pull-up
  assign dq = (dev_dq_oe ? dev_dq_o : 1'b1) & (mst_dq_oe ? mst_dq_o : 1'b1);

  modport dev (input dq, output dev_dq_o, output dev_dq_oe);
  modport mst (input dq, output mst_dq_o, output mst_dq_oe);
endinterface

// [src/swr_slave.sv]
// Purpose: slave end: reset/presence, rom function commands, selection
// Assumes: line level synchronous to i_core_clk; master keeps slot timing
// Notes:   memory command set is outside; first byte after selection is handed out

// Functional notes
// - all fields travel least significant bit first
// - rom is family, serial, crc high byte
// - pin only pulls low or releases
// - low beyond 480 us resets slave
// - high idle between slots never times out
// - reset, rom command, memory command, data
// - master reset pulse, slaves answer presence
// - rom command decoded after eight bits
// - read rom sends all 64 bits
// - master reads rom only with one slave
// - match rom needs exact 64-bit match
// - skip rom selects without rom exchange
// - master reads after skip only alone
// - search sends bit, complement, samples write
// - mismatching search write drops slave out
// - master decodes search read pairs
// - after 64 search bits slave selected
// - memory commands ignored before rom sequence
// - master checks rom crc, expects zero
module swr_slave #(
  parameter logic [7:0] FAMILY_CODE = 8'h5a,  // arbitrary value
  parameter logic [47:0] SERIAL_NUM = 48'h0000_0000_0001,
  parameter int unsigned RST_CYC = swr_pkg::RST_DET_CYC,
  parameter int unsigned PRES_END = swr_pkg::PRES_END_CYC,
  parameter int unsigned PRES_WAIT = swr_pkg::PRES_WAIT_CYC,
  parameter int unsigned SLOT_CYC = swr_pkg::DEV_SLOT_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  swr_link_if.dev link,
  output logic o_bus_reset,
  output logic o_selected,
  output logic o_mem_cmd_vld,
  output logic [7:0] o_mem_cmd
);
  import swr_pkg::*;

  // ---------------------------------------------------------------
  // rom image and state
  // ---------------------------------------------------------------
  localparam logic [63:0] ROM = {swr_crc56({SERIAL_NUM, FAMILY_CODE}), SERIAL_NUM,
                                 FAMILY_CODE};

  typedef enum logic [2:0] {
    SWR_ST_IDLE, SWR_ST_PRES, SWR_ST_CMD, SWR_ST_READ, SWR_ST_MATCH, SWR_ST_SRCH,
    SWR_ST_SEL, SWR_ST_DONE
  } swr_state_e;

  swr_state_e state_q;
  logic dq_q;
  logic [CNT_W-1:0] lo_cnt_q;
  logic rst_seen_q;
  logic [CNT_W-1:0] tmr_q;
  logic slot_act_q;
  logic [5:0] idx_q;
  logic [1:0] phase_q;
  logic [7:0] sh_q;
  logic oe_q;
  logic fall;
  logic rise;
  logic rst_hit;
  logic slot_state;
  logic slot_end;
  logic tx_zero;
  logic rb;
  logic [7:0] nxt_sh;
  logic last_bit;

  // ---------------------------------------------------------------
  // line edges and bus reset detection
  // ---------------------------------------------------------------
  // previous line level, for edge detection
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      dq_q <= 1'b1;
    end else begin
      dq_q <= link.dq;
    end
  end

  assign fall = dq_q & ~link.dq;
  assign rise = ~dq_q & link.dq;
  assign rb = link.dq;
  assign rst_hit = ~link.dq && (lo_cnt_q == CNT_W'(RST_CYC - 1));

  // low-time counter; saturates so a stuck line resets only once
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      lo_cnt_q <= '0;
      rst_seen_q <= 1'b0;
      o_bus_reset <= 1'b0;
    end else begin
      o_bus_reset <= 1'b0;
      if (link.dq) begin
        lo_cnt_q <= '0;
      end else if (lo_cnt_q != CNT_W'(RST_CYC)) begin
        lo_cnt_q <= lo_cnt_q + 1'b1;
      end
      if (rst_hit) begin
        rst_seen_q <= 1'b1;
        o_bus_reset <= 1'b1;
      end else if (rise) begin
        rst_seen_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // slot and presence timer
  // ---------------------------------------------------------------
  assign slot_state = (state_q == SWR_ST_CMD) || (state_q == SWR_ST_READ) ||
                      (state_q == SWR_ST_MATCH) || (state_q == SWR_ST_SRCH) ||
                      (state_q == SWR_ST_SEL);
  assign slot_end = slot_act_q && (tmr_q == CNT_W'(SLOT_CYC - 1));

  // timer restarts on every falling edge outside presence and at the reset-end rise; idle high time is unbounded
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      tmr_q <= '0;
      slot_act_q <= 1'b0;
    end else begin
      if (rst_hit) begin
        slot_act_q <= 1'b0;
      end else if (fall && slot_state && !slot_act_q) begin
        slot_act_q <= 1'b1;
      end else if (slot_end) begin
        slot_act_q <= 1'b0;
      end
      if ((rise && rst_seen_q) || (fall && state_q != SWR_ST_PRES)) begin  // own pull ignored
        tmr_q <= '0;
      end else if (tmr_q != '1) begin
        tmr_q <= tmr_q + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // transmit bit selection and pin drive
  // ---------------------------------------------------------------
  // a zero is sent by pulling low through the slot; a one leaves it high
  always_comb begin
    tx_zero = 1'b0;
    case (state_q)
      SWR_ST_READ: tx_zero = ~ROM[idx_q];
      SWR_ST_SRCH: begin
        if (phase_q == 2'd0) begin
          tx_zero = ~ROM[idx_q];
        end else if (phase_q == 2'd1) begin
          tx_zero = ROM[idx_q];
        end
      end
      default: tx_zero = 1'b0;
    endcase
  end

  // open drain: the output level is always low, only the enable moves
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      oe_q <= 1'b0;
    end else if (rst_hit) begin
      oe_q <= 1'b0;
    end else if (state_q == SWR_ST_PRES) begin
      oe_q <= (tmr_q >= CNT_W'(PRES_WAIT)) && (tmr_q < CNT_W'(PRES_END - 1));
    end else if (fall && slot_state && !slot_act_q) begin
      oe_q <= tx_zero;
    end else if (slot_end) begin
      oe_q <= 1'b0;
    end
  end

  assign link.dev_dq_oe = oe_q;
  assign link.dev_dq_o = 1'b0;

  // ---------------------------------------------------------------
  // rom function sequencer
  // ---------------------------------------------------------------
  assign nxt_sh = {rb, sh_q[7:1]};
  assign last_bit = (idx_q == 6'd63);

  // all bit decisions fall at the slot end, when the written level is stable
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      state_q <= SWR_ST_IDLE;
      idx_q <= '0;
      phase_q <= '0;
      sh_q <= '0;
      o_selected <= 1'b0;
      o_mem_cmd_vld <= 1'b0;
      o_mem_cmd <= '0;
    end else begin
      o_mem_cmd_vld <= 1'b0;
      if (rst_hit) begin
        state_q <= SWR_ST_IDLE;
        o_selected <= 1'b0;
      end else if (rise && rst_seen_q) begin
        state_q <= SWR_ST_PRES;
        idx_q <= '0;
        phase_q <= '0;
        o_selected <= 1'b0;
      end else begin
        case (state_q)
          SWR_ST_PRES: begin
            if (tmr_q == CNT_W'(PRES_END - 1)) begin
              state_q <= SWR_ST_CMD;
            end
          end
          SWR_ST_CMD: begin
            if (slot_end) begin
              sh_q <= nxt_sh;
              idx_q <= idx_q + 1'b1;
              if (idx_q == 6'd7) begin
                idx_q <= '0;
                phase_q <= '0;
                if (nxt_sh == CMD_READ_ROM) begin
                  state_q <= SWR_ST_READ;
                end else if (nxt_sh == CMD_MATCH_ROM) begin
                  state_q <= SWR_ST_MATCH;
                end else if (nxt_sh == CMD_SKIP_ROM) begin
                  state_q <= SWR_ST_SEL;
                  o_selected <= 1'b1;
                end else if (nxt_sh == CMD_SEARCH_ROM) begin
                  state_q <= SWR_ST_SRCH;
                end else begin
                  state_q <= SWR_ST_DONE;
                end
              end
            end
          end
          SWR_ST_READ: begin
            if (slot_end) begin
              idx_q <= idx_q + 1'b1;
              if (last_bit) begin
                state_q <= SWR_ST_SEL;
                o_selected <= 1'b1;
              end
            end
          end
          SWR_ST_MATCH: begin
            if (slot_end) begin
              idx_q <= idx_q + 1'b1;
              if (rb != ROM[idx_q]) begin
                state_q <= SWR_ST_DONE;
              end else if (last_bit) begin
                state_q <= SWR_ST_SEL;
                o_selected <= 1'b1;
              end
            end
          end
          SWR_ST_SRCH: begin
            if (slot_end) begin
              if (phase_q != 2'd2) begin
                phase_q <= phase_q + 1'b1;
              end else if (rb != ROM[idx_q]) begin
                state_q <= SWR_ST_DONE;
              end else begin
                phase_q <= '0;
                idx_q <= idx_q + 1'b1;
                if (last_bit) begin
                  state_q <= SWR_ST_SEL;
                  o_selected <= 1'b1;
                end
              end
            end
          end
          SWR_ST_SEL: begin
            // first memory command byte, only reachable once selected
            if (slot_end) begin
              sh_q <= nxt_sh;
              idx_q <= idx_q + 1'b1;
              if (idx_q == 6'd7) begin
                o_mem_cmd <= nxt_sh;
                o_mem_cmd_vld <= 1'b1;
                state_q <= SWR_ST_DONE;
              end
            end
          end
          default: state_q <= state_q;  // idle and done wait for reset
        endcase
      end
    end
  end

endmodule

// [src/swr_master.sv]
// Purpose: master end: reset pulse, byte write/read and search triplets
// Assumes: user waits for o_busy low before issuing the next operation
// Notes:   choice of rom command and slave count is the user's duty
module swr_master #(
  parameter int unsigned RST_LOW = swr_pkg::RST_LOW_CYC,
  parameter int unsigned RST_WAIT = swr_pkg::RST_WAIT_CYC,
  parameter int unsigned PRES_SMP = swr_pkg::PRES_SMP_CYC,
  parameter int unsigned SLOT = swr_pkg::MST_SLOT_CYC,
  parameter int unsigned W0_LOW = swr_pkg::W0_LOW_CYC,
  parameter int unsigned SHORT_LOW = swr_pkg::SHORT_LOW_CYC,
  parameter int unsigned RD_SMP = swr_pkg::RD_SMP_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  swr_link_if.mst link,
  input wire logic i_op_vld,
  input wire swr_pkg::swr_op_e i_op,
  input wire logic [7:0] i_wr_byte,
  input wire logic i_dir,
  output logic o_busy,
  output logic o_done,
  output logic o_presence,
  output logic o_no_dev,
  output logic [7:0] o_rd_byte,
  output logic [7:0] o_crc
);
  import swr_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SWR_M_IDLE, SWR_M_RLOW, SWR_M_RWAIT, SWR_M_SLOT} swr_mst_e;

  swr_mst_e st_q;
  swr_op_e op_q;
  logic [CNT_W-1:0] tmr_q;
  logic [7:0] sh_q;
  logic [2:0] nb_q;
  logic dir_q;
  logic oe_q;
  logic slot_last;
  logic trip_a;
  logic trip_b;

  assign slot_last = (op_q == SWR_OP_TRIPLET) ? (nb_q == 3'd2) : (nb_q == 3'd7);
  assign trip_a = o_rd_byte[6];
  assign trip_b = o_rd_byte[7];
  assign link.mst_dq_oe = oe_q;
  assign link.mst_dq_o = 1'b0;

  // ---------------------------------------------------------------
  // operation sequencer
  // ---------------------------------------------------------------
  // read slots are write-one slots: short low, then the slave may hold low
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      st_q <= SWR_M_IDLE;
      op_q <= SWR_OP_RESET;
      tmr_q <= '0;
      sh_q <= '0;
      nb_q <= '0;
      dir_q <= 1'b0;
      oe_q <= 1'b0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_presence <= 1'b0;
      o_no_dev <= 1'b0;
      o_rd_byte <= '0;
      o_crc <= '0;
    end else begin
      o_done <= 1'b0;
      tmr_q <= tmr_q + 1'b1;
      case (st_q)
        SWR_M_IDLE: begin
          tmr_q <= '0;
          if (i_op_vld) begin
            op_q <= i_op;
            dir_q <= i_dir;
            nb_q <= '0;
            o_busy <= 1'b1;
            oe_q <= 1'b1;
            o_no_dev <= 1'b0;
            sh_q <= (i_op == SWR_OP_WRITE) ? i_wr_byte : 8'hff;
            if (i_op == SWR_OP_RESET) begin
              st_q <= SWR_M_RLOW;
              o_crc <= '0;
              o_presence <= 1'b0;
            end else begin
              st_q <= SWR_M_SLOT;
            end
          end
        end
        SWR_M_RLOW: begin
          if (tmr_q == CNT_W'(RST_LOW - 1)) begin
            oe_q <= 1'b0;
            tmr_q <= '0;
            st_q <= SWR_M_RWAIT;
          end
        end
        SWR_M_RWAIT: begin
          if (tmr_q == CNT_W'(PRES_SMP - 1)) begin
            o_presence <= ~link.dq;
          end
          if (tmr_q == CNT_W'(RST_WAIT - 1)) begin
            st_q <= SWR_M_IDLE;
            o_busy <= 1'b0;
            o_done <= 1'b1;
          end
        end
        SWR_M_SLOT: begin
          if (tmr_q == CNT_W'((sh_q[0] ? SHORT_LOW : W0_LOW) - 1)) begin
            oe_q <= 1'b0;
          end
          if (tmr_q == CNT_W'(RD_SMP - 1)) begin
            o_rd_byte <= {link.dq, o_rd_byte[7:1]};
            if (op_q == SWR_OP_READ) begin
              o_crc <= swr_crc_bit(o_crc, link.dq);
            end
          end
          if (tmr_q == CNT_W'(SLOT - 1)) begin
            tmr_q <= '0;
            nb_q <= nb_q + 1'b1;
            sh_q <= {1'b1, sh_q[7:1]};
            if (op_q == SWR_OP_TRIPLET && nb_q == 3'd1) begin
              if (trip_a && trip_b) begin
                o_no_dev <= 1'b1;
                st_q <= SWR_M_IDLE;
                o_busy <= 1'b0;
                o_done <= 1'b1;
              end else begin
                oe_q <= 1'b1;
                sh_q[0] <= (trip_a != trip_b) ? trip_a : dir_q;
              end
            end else if (slot_last) begin
              st_q <= SWR_M_IDLE;
              o_busy <= 1'b0;
              o_done <= 1'b1;
            end else begin
              oe_q <= 1'b1;
            end
          end
        end
        default: st_q <= SWR_M_IDLE;
      endcase
    end
  end

endmodule

// [verification/swr_link_asserts.sv]
// Purpose: wire-level checks on the shared line between master and slave
// Assumes: one slave and one master on the line, shortened reset counts
// Notes:   helper counters measure low runs and time since a reset pulse
module swr_link_asserts
  import swr_pkg::*;
#(
  parameter int unsigned RST_CYC = 4000,
  parameter int unsigned PRES_END = 4000,
  parameter int unsigned RST_LOW = 4500,
  parameter int unsigned W0_LOW = 3050,
  parameter int unsigned PRES_WAIT = 3000,
  parameter int unsigned SLOT_CYC = 3000
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic dev_dq_o,
  input wire logic dev_dq_oe,
  input wire logic mst_dq_o,
  input wire logic mst_dq_oe,
  input wire logic dq
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  int unsigned low_q;
  int unsigned dev_run_q;
  int unsigned mst_run_q;
  int unsigned after_q;
  logic pres_q;
  logic rst_end;

  assign rst_end = dq && (low_q >= RST_CYC);  // line rises after a long low

  // consecutive low samples, saturating so it never wraps
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b || dq) low_q <= 0;
    else if (low_q < RST_CYC + 8) low_q <= low_q + 1;
  end

  // length of each pull by either end
  always_ff @(posedge i_core_clk) begin
    dev_run_q <= (i_rst_b && dev_dq_oe) ? dev_run_q + 1 : 0;
    mst_run_q <= (i_rst_b && mst_dq_oe) ? mst_run_q + 1 : 0;
  end

  // cycles since the end of a reset pulse, only over the presence window
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) after_q <= 0;
    else if (rst_end) after_q <= 1;
    else if (after_q != 0 && after_q < PRES_END + 4) after_q <= after_q + 1;
    else after_q <= 0;
  end

  // presence seen since the last reset pulse
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b || rst_end) pres_q <= 1'b0;
    else if (after_q != 0 && dev_dq_oe) pres_q <= 1'b1;
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  property p_dev_od;
    dev_dq_oe |-> dev_dq_o == 1'b0;
  endproperty
  a_dev_od: assert property (p_dev_od) else $error("slave drives line high");

  property p_mst_od;
    mst_dq_oe |-> !mst_dq_o;
  endproperty
  a_mst_od: assert property (p_mst_od) else $error("master drives line high");

  property p_rst_release;
    low_q >= RST_CYC |-> !dev_dq_oe;
  endproperty
  a_rst_release: assert property (p_rst_release) else $error("slave pulls in reset");

  property p_pres_window;
    (after_q != 0 && dev_dq_oe) |-> (after_q >= PRES_WAIT - 1 && after_q <= PRES_END + 1);
  endproperty
  a_pres_window: assert property (p_pres_window) else $error("presence out of window");

  property p_pres_given;
    after_q == PRES_END + 2 |-> pres_q;
  endproperty
  a_pres_given: assert property (p_pres_given) else $error("no presence after reset");

  property p_slot_reply;
    ($rose(dev_dq_oe) && after_q == 0) |-> $past(!dq) && $past(mst_dq_oe);
  endproperty
  a_slot_reply: assert property (p_slot_reply) else $error("slave pull without slot");

  property p_dev_hold;
    $fell(dev_dq_oe) |-> (dev_run_q inside {[SLOT_CYC - 1:SLOT_CYC + 1]}) ||
      (dev_run_q inside {[PRES_END - PRES_WAIT - 1:PRES_END - PRES_WAIT + 1]});
  endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("slave pull length wrong");

  property p_mst_len;
    $fell(mst_dq_oe) |-> (mst_run_q <= W0_LOW + 1) ||
      (mst_run_q inside {[RST_LOW - 1:RST_LOW + 1]});
  endproperty
  a_mst_len: assert property (p_mst_len) else $error("master low length wrong");
endmodule

// [verification/tb.sv]
// Purpose: drives both ends through reset, rom commands and selection
// Assumes: one slave, shortened reset and presence counts
// Notes:   expected rom and crc are rebuilt here from the slave parameters
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import swr_pkg::*;

  // ---------------------------------------------------------------
  // setup
  // ---------------------------------------------------------------
  localparam logic [7:0] FAM = 8'h3c;  // arbitrary value
  localparam logic [47:0] SER = 48'h0000_0012_3456;  // arbitrary value
  localparam int unsigned LIMIT = 80000;  // run needs about 45000 cycles

  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic op_vld = 1'b0;
  swr_op_e op = SWR_OP_RESET;
  logic [7:0] wr_byte = 8'h00;
  logic dir = 1'b0;
  logic busy, done, presence, no_dev, bus_reset, selected, mem_vld;
  logic [7:0] rd_byte, mst_crc, mem_cmd, wire_bits;
  logic [63:0] rom;
  int unsigned err_count = 0, samples_checked = 0, cyc = 0, mrun = 0;
  int unsigned rst_cnt = 0, mem_cnt = 0, n_init = 0;

  // reference crc, lsb first shift register
  function automatic logic [7:0] crc8(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC_POLY_REV) : (c >> 1);
    return c;
  endfunction
  assign rom = {crc8({SER, FAM}), SER, FAM};

  always #5 i_core_clk = ~i_core_clk;

  swr_link_if link_if();
  // one cycle per microsecond on the line, so whole transactions stay short
  swr_slave #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER), .RST_CYC(RST_DET_US), .PRES_END(PRES_END_US),
    .PRES_WAIT(PRES_WAIT_US), .SLOT_CYC(DEV_SLOT_US)) swr_slave_i (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .link(link_if), .o_bus_reset(bus_reset),
    .o_selected(selected), .o_mem_cmd_vld(mem_vld), .o_mem_cmd(mem_cmd));
  // reset low beats slave detection, wait beats the presence end
  swr_master #(.RST_LOW(RST_LOW_US), .RST_WAIT(RST_WAIT_US), .PRES_SMP(PRES_SMP_US),
    .SLOT(MST_SLOT_US), .W0_LOW(W0_LOW_US), .SHORT_LOW(SHORT_LOW_US), .RD_SMP(RD_SMP_US))
    swr_master_i (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .link(link_if), .i_op_vld(op_vld), .i_op(op),
    .i_wr_byte(wr_byte), .i_dir(dir), .o_busy(busy), .o_done(done), .o_presence(presence),
    .o_no_dev(no_dev), .o_rd_byte(rd_byte), .o_crc(mst_crc));
  swr_link_asserts #(.RST_CYC(RST_DET_US), .PRES_END(PRES_END_US), .RST_LOW(RST_LOW_US),
    .W0_LOW(W0_LOW_US), .PRES_WAIT(PRES_WAIT_US), .SLOT_CYC(DEV_SLOT_US)) swr_link_asserts_i (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .dev_dq_o(link_if.dev_dq_o),
    .dev_dq_oe(link_if.dev_dq_oe), .mst_dq_o(link_if.mst_dq_o),
    .mst_dq_oe(link_if.mst_dq_oe), .dq(link_if.dq));

  // ---------------------------------------------------------------
  // monitors
  // ---------------------------------------------------------------
  // decode master slots from the master's pull enable: short low is a one
  always @(posedge i_core_clk) begin
    if (link_if.mst_dq_oe === 1'b1) mrun <= mrun + 1;
    else begin
      if (mrun != 0 && mrun < RST_DET_US) wire_bits <= {mrun < DEV_SLOT_US, wire_bits[7:1]};
      mrun <= 0;
    end
  end

  // count slave pulses where they are settled, plus hang guard
  always @(negedge i_core_clk) begin
    if (bus_reset === 1'b1) rst_cnt++;
    if (mem_vld === 1'b1) mem_cnt++;
    cyc++;
    if (cyc == LIMIT) begin
      err_count++;
      results();
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one master operation, returns once its done pulse has been seen
  task automatic do_op(input swr_op_e o, input logic [7:0] b);
    @(posedge i_core_clk);
    op_vld <= 1'b1;
    op <= o;
    wr_byte <= b;
    @(posedge i_core_clk);
    op_vld <= 1'b0;
    do @(negedge i_core_clk); while (done !== 1'b1);
  endtask

  task automatic bus_init();
    do_op(SWR_OP_RESET, 8'h00);
    n_init++;
    chk({7'h00, presence}, 8'h01);
    chk({7'h00, selected}, 8'h00);
    chk({7'h00, busy}, 8'h00);
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    // skip, long idle, then one memory byte
    bus_init();
    do_op(SWR_OP_WRITE, CMD_SKIP_ROM);
    chk(wire_bits, CMD_SKIP_ROM);
    chk({7'h00, selected}, 8'h01);
    chk(8'(mem_cnt), 8'h00);
    repeat (20000) @(posedge i_core_clk);
    do_op(SWR_OP_WRITE, 8'h96);
    chk(8'(mem_cnt), 8'h01);
    chk(mem_cmd, 8'h96);
    // unknown code leaves the slave silent
    bus_init();
    do_op(SWR_OP_WRITE, 8'ha5);
    do_op(SWR_OP_WRITE, 8'h11);
    chk(8'(mem_cnt), 8'h01);
    do_op(SWR_OP_READ, 8'h00);
    chk(rd_byte, 8'hff);
    // read the whole rom, crc closes to zero
    bus_init();
    do_op(SWR_OP_WRITE, CMD_READ_ROM);
    for (int i = 0; i < 8; i++) begin
      do_op(SWR_OP_READ, 8'h00);
      chk(rd_byte, rom[8*i +: 8]);
    end
    chk(mst_crc, 8'h00);
    chk({7'h00, selected}, 8'h01);
    // match fails on the last bit of the first byte
    bus_init();
    do_op(SWR_OP_WRITE, CMD_MATCH_ROM);
    do_op(SWR_OP_WRITE, rom[7:0] ^ 8'h80);
    do_op(SWR_OP_WRITE, 8'h22);
    chk({7'h00, selected}, 8'h00);
    chk(8'(mem_cnt), 8'h01);
    // exact match selects and takes a memory byte
    bus_init();
    do_op(SWR_OP_WRITE, CMD_MATCH_ROM);
    for (int i = 0; i < 8; i++) do_op(SWR_OP_WRITE, rom[8*i +: 8]);
    chk(wire_bits, rom[63:56]);
    chk({7'h00, selected}, 8'h01);
    do_op(SWR_OP_WRITE, 8'h5e);
    chk(8'(mem_cnt), 8'h02);
    chk(mem_cmd, 8'h5e);
    // search over the family byte, then reset mid-pass
    bus_init();
    do_op(SWR_OP_WRITE, CMD_SEARCH_ROM);
    for (int i = 0; i < 8; i++) begin
      do_op(SWR_OP_TRIPLET, 8'h00);
      chk({5'h00, rd_byte[7:5]}, {5'h00, rom[i], ~rom[i], rom[i]});
      chk({7'h00, no_dev}, 8'h00);
    end
    bus_init();
    chk(8'(rst_cnt), 8'(n_init));
    results();
  end
endmodule
